// [core/i2cbc_pkg.sv]
// i2cbc_pkg: offsets, fields, reset values and timing of the bus control block
// assumes a 10 MHz pclk and a 12-bit apb byte address
package i2cbc_pkg;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] CSR_IDX = 8'h02;
	localparam logic [7:0] CTL_IDX = 8'h03;
	localparam logic [7:0] OWN_IDX = 8'h04;
	localparam logic [7:0] IRQ_STAT_IDX = 8'h05;
	localparam logic [7:0] IRQ_CLR_IDX = 8'h06;
	localparam logic [7:0] IRQ_EN_IDX = 8'h07;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CSR_TGL_BIT = 5;
	localparam int unsigned CSR_SENSE_BIT = 4;
	localparam int unsigned CSR_GC_BIT = 3;
	localparam int unsigned CSR_MATCH_BIT = 2;
	localparam int unsigned CSR_OCC_BIT = 1;
	localparam int unsigned CSR_BUSY_BIT = 0;
	localparam int unsigned CTL_EN_BIT = 0;
	localparam int unsigned CTL_GC_EN_BIT = 5;
	localparam int unsigned OWN_EN_BIT = 7;
	localparam int unsigned IRQ_MATCH_BIT = 0;
	localparam int unsigned IRQ_GC_BIT = 1;
	localparam int unsigned IRQ_STOP_BIT = 2;
	localparam int unsigned IRQ_TGL_BIT = 3;

	// ------------------------------------------------------------
	// reset values and general call address
	// ------------------------------------------------------------
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] OWN_RST = 8'h00;
	localparam logic [3:0] IRQ_RST = 4'h0;
	localparam logic [7:0] GC_ADDR = 8'h00;

	// ------------------------------------------------------------
	// timing of the recovery clock pulse
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TGL_LOW_NS = 5000;
	localparam int unsigned TGL_HIGH_NS = 5000;
	localparam int unsigned TGL_LOW_CYC = (TGL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TGL_HIGH_CYC = (TGL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	function automatic logic [11:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'b00, idx, 2'b00};
	endfunction : reg_addr

endpackage : i2cbc_pkg

// [core/i2cbc_line_watch.sv]
// i2cbc_line_watch: start, stop and first-byte detection on the two-wire bus
// assumes scl and sda already synchronised to pclk
module i2cbc_line_watch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_s,
	input wire logic sda_s,
	output logic start_p,
	output logic stop_p,
	output logic byte_p,
	output logic [7:0] byte_q
);

	logic scl_d_reg, scl_d_next;
	logic sda_d_reg, sda_d_next;
	logic armed_reg, armed_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] shf_reg, shf_next;
	logic start_reg, start_next;
	logic stop_reg, stop_next;
	logic byte_reg, byte_next;
	logic st_c, sp_c, rise_c;

	// ------------------------------------------------------------
	// conditions; any start or stop counts, legal or not
	// ------------------------------------------------------------
	always_comb begin
		st_c = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
		sp_c = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
		rise_c = scl_s & ~scl_d_reg;
		scl_d_next = scl_s;
		sda_d_next = sda_s;
		armed_next = armed_reg;
		cnt_next = cnt_reg;
		shf_next = shf_reg;
		byte_next = 1'b0;
		start_next = st_c;
		stop_next = sp_c;
		if (st_c) begin
			armed_next = 1'b1;
			cnt_next = 4'h0;
		end else if (sp_c) begin
			armed_next = 1'b0;
		end else if (armed_reg && rise_c) begin
			shf_next = {shf_reg[6:0], sda_s};
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg == 4'h7) begin
				armed_next = 1'b0;
				byte_next = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			armed_reg <= 1'b0;
			cnt_reg <= 4'h0;
			shf_reg <= 8'h00;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			byte_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
			armed_reg <= armed_next;
			cnt_reg <= cnt_next;
			shf_reg <= shf_next;
			start_reg <= start_next;
			stop_reg <= stop_next;
			byte_reg <= byte_next;
		end
	end

	assign start_p = start_reg;
	assign stop_p = stop_reg;
	assign byte_p = byte_reg;
	assign byte_q = shf_reg;

endmodule : i2cbc_line_watch

// [core/i2cbc_ctrl_status.sv]
// i2cbc_ctrl_status: control-status register of the two-wire interface on apb
// assumes the master and start generator sit outside and report on same-clock inputs
// Operation
// - reset clears all register bits, disable only the status and toggle bits
// - toggle write with data low pulses clock
// - toggle write with data high ignored
// - toggle bit reads zero when done
// - sense bit shows live data line
// - general call byte 00h sets flag
// - start or stop clears both match flags
// - own address match sets match flag
// - start or low line sets occupied
// - occupied cleared by one, disable, stop
// - busy from start until address received
// - busy also for start, master, matches
module i2cbc_ctrl_status (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic start_gen,
	input wire logic master_active_flag,
	output logic irq
);

	// ------------------------------------------------------------
	// types and declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TG_IDLE = 3'b001,
		TG_LOW = 3'b010,
		TG_HIGH = 3'b100
	} i2cbc_tgl_t;

	i2cbc_tgl_t tgl_reg, tgl_next;
	logic [7:0] tcnt_reg, tcnt_next;
	logic scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
	logic [7:0] ctl_reg, ctl_next;
	logic [7:0] own_reg, own_next;
	logic match_reg, match_next;
	logic gc_reg, gc_next;
	logic occ_reg, occ_next;
	logic win_reg, win_next;
	logic [3:0] ist_reg, ist_next;
	logic [3:0] ien_reg, ien_next;
	logic [31:0] rd_reg, rd_next;
	logic oe_n_reg, oe_n_next;
	logic start_p, stop_p, byte_p;
	logic [7:0] byte_q;
	logic wr_en, rd_setup, mapped;
	logic csr_wr;
	logic en, busy_c, tgl_done;
	logic [7:0] csr_rd;
	logic [3:0] ev;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// idle level 1 after reset, so no false start follows it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
		end else begin
			scl_m_reg <= scl_in;
			scl_s_reg <= scl_m_reg;
			sda_m_reg <= sda_in;
			sda_s_reg <= sda_m_reg;
		end
	end

	// conditions arrive one edge after the synchronised levels
	i2cbc_line_watch i2cbc_line_watch_inst (
		.pclk(pclk),
		.presetn(presetn),
		.scl_s(scl_s_reg),
		.sda_s(sda_s_reg),
		.start_p(start_p),
		.stop_p(stop_p),
		.byte_p(byte_p),
		.byte_q(byte_q)
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero-wait access; read data is caught in the setup cycle
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a == i2cbc_pkg::reg_addr(idx));
	endfunction : hit

	always_comb begin
		mapped = hit(paddr, i2cbc_pkg::CSR_IDX) | hit(paddr, i2cbc_pkg::CTL_IDX)
			| hit(paddr, i2cbc_pkg::OWN_IDX) | hit(paddr, i2cbc_pkg::IRQ_STAT_IDX)
			| hit(paddr, i2cbc_pkg::IRQ_CLR_IDX) | hit(paddr, i2cbc_pkg::IRQ_EN_IDX);
		wr_en = psel & penable & pwrite & mapped;
		rd_setup = psel & ~penable & ~pwrite;
		csr_wr = wr_en & hit(paddr, i2cbc_pkg::CSR_IDX);
	end

	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign en = ctl_reg[i2cbc_pkg::CTL_EN_BIT];

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_comb begin
		ctl_next = ctl_reg;
		own_next = own_reg;
		ien_next = ien_reg;
		if (wr_en && hit(paddr, i2cbc_pkg::CTL_IDX)) begin
			ctl_next = pwdata[7:0];
		end
		if (wr_en && hit(paddr, i2cbc_pkg::OWN_IDX)) begin
			own_next = pwdata[7:0];
		end
		if (wr_en && hit(paddr, i2cbc_pkg::IRQ_EN_IDX)) begin
			ien_next = pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= i2cbc_pkg::CTL_RST;
			own_reg <= i2cbc_pkg::OWN_RST;
			ien_reg <= i2cbc_pkg::IRQ_RST;
		end else begin
			ctl_reg <= ctl_next;
			own_reg <= own_next;
			ien_reg <= ien_next;
		end
	end

	// ------------------------------------------------------------
	// recovery clock toggle
	// ------------------------------------------------------------
	// only pulls scl low; the high phase count runs on even while a slave stretches it
	always_comb begin
		tgl_next = tgl_reg;
		tcnt_next = tcnt_reg;
		tgl_done = 1'b0;
		case (tgl_reg)
			TG_IDLE: begin
				if (csr_wr && en
						&& pwdata[i2cbc_pkg::CSR_TGL_BIT] && !sda_s_reg) begin
					tgl_next = TG_LOW;
					tcnt_next = 8'(i2cbc_pkg::TGL_LOW_CYC - 1);
				end
			end
			TG_LOW: begin
				if (tcnt_reg == 8'h00) begin
					tgl_next = TG_HIGH;
					tcnt_next = 8'(i2cbc_pkg::TGL_HIGH_CYC - 1);
				end else begin
					tcnt_next = tcnt_reg - 8'h01;
				end
			end
			TG_HIGH: begin
				if (tcnt_reg == 8'h00) begin
					tgl_next = TG_IDLE;
					tgl_done = 1'b1;
				end else begin
					tcnt_next = tcnt_reg - 8'h01;
				end
			end
			default: begin
				tgl_next = TG_IDLE;
				tcnt_next = 8'h00;
			end
		endcase
		if (!en) begin
			tgl_next = TG_IDLE;
			tcnt_next = 8'h00;
			tgl_done = 1'b0;
		end
		oe_n_next = (tgl_next != TG_LOW);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgl_reg <= TG_IDLE;
			tcnt_reg <= 8'h00;
			oe_n_reg <= 1'b1;
		end else begin
			tgl_reg <= tgl_next;
			tcnt_reg <= tcnt_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign scl_out = 1'b0;
	assign scl_oe_n = oe_n_reg;

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	always_comb begin
		match_next = match_reg;
		gc_next = gc_reg;
		win_next = win_reg;
		occ_next = occ_reg;
		if (start_p || stop_p) begin
			match_next = 1'b0;
			gc_next = 1'b0;
		end else if (byte_p) begin
			if (own_reg[i2cbc_pkg::OWN_EN_BIT] && byte_q[7:1] == own_reg[6:0]) begin
				match_next = 1'b1;
			end
			if (ctl_reg[i2cbc_pkg::CTL_GC_EN_BIT] && byte_q == i2cbc_pkg::GC_ADDR) begin
				gc_next = 1'b1;
			end
		end
		if (start_p) begin
			win_next = 1'b1;
		end else if (byte_p || stop_p) begin
			win_next = 1'b0;
		end
		// a set in the same cycle as a write-one or stop clear wins; disable beats both
		if (csr_wr && pwdata[i2cbc_pkg::CSR_OCC_BIT]) begin
			occ_next = 1'b0;
		end
		if (stop_p) begin
			occ_next = 1'b0;
		end
		if (start_p || !scl_s_reg || !sda_s_reg) begin
			occ_next = 1'b1;
		end
		if (!en) begin
			match_next = 1'b0;
			gc_next = 1'b0;
			win_next = 1'b0;
			occ_next = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_reg <= 1'b0;
			gc_reg <= 1'b0;
			win_reg <= 1'b0;
			occ_reg <= 1'b0;
		end else begin
			match_reg <= match_next;
			gc_reg <= gc_next;
			win_reg <= win_next;
			occ_reg <= occ_next;
		end
	end

	// busy bit ignores written data, software is expected to write 0
	always_comb begin
		busy_c = en & (win_reg | start_gen | master_active_flag
			| match_reg | gc_reg);
		csr_rd = 8'h00;
		csr_rd[i2cbc_pkg::CSR_TGL_BIT] = (tgl_reg != TG_IDLE);
		// gated too, so a disabled interface reads all zero
		csr_rd[i2cbc_pkg::CSR_SENSE_BIT] = en & sda_s_reg;
		csr_rd[i2cbc_pkg::CSR_GC_BIT] = gc_reg;
		csr_rd[i2cbc_pkg::CSR_MATCH_BIT] = match_reg;
		csr_rd[i2cbc_pkg::CSR_OCC_BIT] = occ_reg;
		csr_rd[i2cbc_pkg::CSR_BUSY_BIT] = busy_c;
	end

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	always_comb begin
		ev = 4'h0;
		ev[i2cbc_pkg::IRQ_MATCH_BIT] = match_next & ~match_reg;
		ev[i2cbc_pkg::IRQ_GC_BIT] = gc_next & ~gc_reg;
		ev[i2cbc_pkg::IRQ_STOP_BIT] = stop_p & en;
		ev[i2cbc_pkg::IRQ_TGL_BIT] = tgl_done;
		ist_next = ist_reg;
		if (wr_en && hit(paddr, i2cbc_pkg::IRQ_CLR_IDX)) begin
			ist_next = ist_reg & ~pwdata[3:0];
		end
		// events are or-ed last, so a set beats a clear
		ist_next = ist_next | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_reg <= i2cbc_pkg::IRQ_RST;
		end else begin
			ist_reg <= ist_next;
		end
	end

	assign irq = |(ist_reg & ien_reg);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb begin
		rd_next = rd_reg;
		if (rd_setup) begin
			rd_next = 32'h0000_0000;
			// unmapped and write-only words read zero
			if (hit(paddr, i2cbc_pkg::CSR_IDX)) begin
				rd_next[7:0] = csr_rd;
			end
			if (hit(paddr, i2cbc_pkg::CTL_IDX)) begin
				rd_next[7:0] = ctl_reg;
			end
			if (hit(paddr, i2cbc_pkg::OWN_IDX)) begin
				rd_next[7:0] = own_reg;
			end
			if (hit(paddr, i2cbc_pkg::IRQ_STAT_IDX)) begin
				rd_next[3:0] = ist_reg;
			end
			if (hit(paddr, i2cbc_pkg::IRQ_EN_IDX)) begin
				rd_next[3:0] = ien_reg;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg <= 32'h0000_0000;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign prdata = rd_reg;

endmodule : i2cbc_ctrl_status

// [testbench/i2cbc_assertions.sv]
// i2cbc_assertions: port checks of the bus control block
// assumes zero-wait apb and a bind from the bench top
module i2cbc_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic start_gen,
	input wire logic master_active_flag,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// helper state
	// ----------------
	logic en_reg;
	logic en_next;
	logic [7:0] low_reg;
	logic [7:0] low_next;
	logic acc;
	logic rd_csr;
	logic tgl_wr;
	assign acc = psel && penable;
	assign rd_csr = acc && !pwrite && paddr == 12'h008;
	assign tgl_wr = acc && pwrite && paddr == 12'h008 && pwdata[5];
	// enable is tracked from apb writes, so no peeking inside
	always_comb begin
		en_next = en_reg;
		if (acc && pwrite && paddr == 12'h00c) begin
			en_next = pwdata[0];
		end
		low_next = scl_oe_n ? 8'h00 : low_reg + 8'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 1'b0;
			low_reg <= 8'h00;
		end else begin
			en_reg <= en_next;
			low_reg <= low_next;
		end
	end
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_tgl_cause: assert property ($fell(scl_oe_n) |-> $past(tgl_wr))
		else $error("clock pulled low without toggle write");
	a_tgl_width: assert property ($rose(scl_oe_n) |-> low_reg == 8'h32)
		else $error("recovery low phase not 50 cycles");
	a_tgl_bound: assert property (low_reg <= 8'h32)
		else $error("recovery low phase too long");
	a_tgl_single: assert property ($rose(scl_oe_n) |-> scl_oe_n [*8])
		else $error("second clock pulse too soon");
	a_tgl_ignored: assert property (tgl_wr && scl_oe_n && sda_in && $past(sda_in)
		&& $past(sda_in, 2) |=> scl_oe_n)
		else $error("toggle acted with data line high");
	a_sense_live: assert property ($stable(sda_in) [*5] ##0 rd_csr && en_reg
		|-> prdata[4] == sda_in)
		else $error("sense bit differs from data line");
	a_off_clear: assert property (rd_csr && !en_reg |-> prdata[7:0] == 8'h00)
		else $error("status not clear while disabled");
	a_master_busy: assert property (master_active_flag [*4] ##0 rd_csr && en_reg
		|-> prdata[0])
		else $error("busy low in master mode");
endmodule : i2cbc_assertions

// [testbench/i2cbc_bus_model.sv]
// i2cbc_bus_model: other parties on the two-wire bus
// assumes pull-ups on both lines and an 800 ns bus clock
module i2cbc_bus_model (
	input wire logic scl_out,
	input wire logic scl_oe_n,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	// ----------------
	// wired lines
	// ----------------
	// wired-and with pull-up; clock stands still between frames
	assign scl = scl_m & (scl_oe_n | scl_out);
	assign sda = sda_m;
	// ----------------
	// conditions
	// ----------------
	// 30 ns skew keeps every change off the pclk edge
	task automatic set_sda(input logic v);
		#30 sda_m = v;
	endtask : set_sda
	task automatic start_c;
		#30 sda_m = 1'b0;
		#400 scl_m = 1'b0;
		#400;
	endtask : start_c
	task automatic stop_c;
		#30 sda_m = 1'b0;
		#400 scl_m = 1'b1;
		#400 sda_m = 1'b1;
		#400;
	endtask : stop_c
	task automatic release_c;
		#30 sda_m = 1'b1;
		#200 scl_m = 1'b1;
		#400;
	endtask : release_c
	task automatic byte_c(input logic [7:0] b);
		#30;
		for (int i = 7; i >= 0; i--) begin
			sda_m = b[i];
			#200 scl_m = 1'b1;
			#400 scl_m = 1'b0;
			#200;
		end
	endtask : byte_c
endmodule : i2cbc_bus_model

// [testbench/i2cbc_ctrl_status_tb.sv]
// i2cbc_ctrl_status_tb: apb scenarios against the bus model
// assumes package, design, model and checker compiled first
module i2cbc_ctrl_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic scl;
	logic sda;
	logic scl_out;
	logic scl_oe_n;
	logic start_gen = 1'b0;
	logic master_active_flag = 1'b0;
	logic irq;
	logic [31:0] rd;
	logic err;
	int n;
	int failures = 0;
	int check_count = 0;
	i2cbc_ctrl_status i2cbc_ctrl_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .start_gen(start_gen), .master_active_flag(master_active_flag),
		.irq(irq));
	i2cbc_bus_model i2cbc_bus_model_inst (.scl_out(scl_out), .scl_oe_n(scl_oe_n), .scl(scl),
		.sda(sda));
	initial begin
		forever #50 pclk = ~pclk;
	end
	// ----------------
	// shared tasks
	// ----------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rcsr(input logic [7:0] m, input logic [7:0] e);
		apb(1'b0, 12'h008, 32'h0);
		chk("csr", {24'h0, e}, rd & {24'h0, m});
	endtask : rcsr
	task automatic settle;
		repeat (8) @(posedge pclk);
	endtask : settle
	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		rcsr(8'hff, 8'h00);
		apb(1'b0, 12'h100, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		apb(1'b1, 12'h00c, 32'h21);
		apb(1'b1, 12'h010, 32'haa);
	endtask : t_reset
	task automatic t_match;
		i2cbc_bus_model_inst.start_c();
		settle();
		rcsr(8'h17, 8'h03);
		i2cbc_bus_model_inst.byte_c(8'h54);
		settle();
		rcsr(8'h0d, 8'h05);
		i2cbc_bus_model_inst.stop_c();
		settle();
		apb(1'b1, 12'h008, 32'h0);
		rcsr(8'h1f, 8'h10);
	endtask : t_match
	task automatic t_gen_call;
		i2cbc_bus_model_inst.start_c();
		i2cbc_bus_model_inst.byte_c(8'h00);
		settle();
		rcsr(8'h0c, 8'h08);
		i2cbc_bus_model_inst.release_c();
		settle();
		rcsr(8'h02, 8'h02);
		apb(1'b1, 12'h008, 32'h02);
		rcsr(8'h0a, 8'h08);
		apb(1'b1, 12'h00c, 32'h0);
		rcsr(8'hff, 8'h00);
		apb(1'b1, 12'h00c, 32'h21);
		rcsr(8'h0c, 8'h00);
		i2cbc_bus_model_inst.start_c();
		i2cbc_bus_model_inst.byte_c(8'h56);
		settle();
		rcsr(8'h0d, 8'h00);
		i2cbc_bus_model_inst.stop_c();
	endtask : t_gen_call
	task automatic t_toggle;
		i2cbc_bus_model_inst.set_sda(1'b0);
		settle();
		apb(1'b1, 12'h008, 32'h20);
		n = 0;
		@(negedge pclk);
		chk("scl_wire", 32'h0, {31'h0, scl});
		while (scl_oe_n === 1'b0 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		chk("low_cycles", 32'd50, n);
		rcsr(8'h20, 8'h20);
		repeat (55) @(posedge pclk);
		rcsr(8'h20, 8'h00);
		apb(1'b0, 12'h014, 32'h0);
		chk("irq_status", 32'h8, rd & 32'h8);
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, 12'h01c, 32'h8);
		@(negedge pclk);
		chk("irq_raised", 32'h1, {31'h0, irq});
		apb(1'b1, 12'h018, 32'h8);
		@(negedge pclk);
		chk("irq_cleared", 32'h0, {31'h0, irq});
		i2cbc_bus_model_inst.set_sda(1'b1);
		settle();
		apb(1'b1, 12'h008, 32'h20);
		repeat (3) @(posedge pclk);
		chk("scl_oe_n", 32'h1, {31'h0, scl_oe_n});
		rcsr(8'h20, 8'h00);
	endtask : t_toggle
	task automatic t_master;
		master_active_flag <= 1'b1;
		settle();
		rcsr(8'h01, 8'h01);
		master_active_flag <= 1'b0;
		start_gen <= 1'b1;
		settle();
		rcsr(8'h01, 8'h01);
		start_gen <= 1'b0;
		settle();
		rcsr(8'h01, 8'h00);
	endtask : t_master
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_match();
		t_gen_call();
		t_toggle();
		t_master();
		print_verdict();
	end
	// run needs well under 2000 cycles
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
endmodule : i2cbc_ctrl_status_tb
bind i2cbc_ctrl_status i2cbc_assertions i2cbc_assertions_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in),
	.scl_out(scl_out), .scl_oe_n(scl_oe_n), .start_gen(start_gen),
	.master_active_flag(master_active_flag), .irq(irq));
